/* File: sixp_pkg.sv */
// Purpose: constants for the six-pin port with function steering
// Assumes: avalon-mm register slave, word addressed by byte address
// Notes: offsets are word aligned byte addresses
package sixp_pkg;
   localparam int NPIN = 6;
   localparam logic [7:0] OFS_DIR = 8'h00;
   localparam logic [7:0] OFS_LVL = 8'h04;
   localparam logic [7:0] OFS_LAT = 8'h08;
   localparam logic [7:0] OFS_ANA = 8'h0c;
   localparam logic [7:0] OFS_OD = 8'h10;
   localparam logic [7:0] OFS_SLR = 8'h14;
   localparam logic [7:0] OFS_THR = 8'h18;
   localparam logic [7:0] OFS_STEER = 8'h1c;
   localparam logic [5:0] DIR_RST = 6'h3f;
   localparam logic [5:0] LAT_RST = 6'h00;
   localparam logic [5:0] ANA_RST = 6'h17;
   localparam logic [5:0] ANA_MASK = 6'h17;
   localparam logic [5:0] OD_RST = 6'h00;
   localparam logic [5:0] SLR_RST = 6'h37;
   localparam logic [5:0] THR_RST = 6'h00;
   localparam logic [7:0] STEER_RST = 8'h00;
   localparam logic [7:0] STEER_MASK = 8'hef;
   localparam logic [5:0] OUT_MASK = 6'h37;
   localparam int INPUT_ONLY_PIN = 3;
   localparam int SB_RX = 7;
   localparam int SB_WA = 6;
   localparam int SB_WB = 5;
   localparam int SB_TG = 3;
   localparam int SB_TX = 2;
   localparam int SB_P2 = 1;
   localparam int SB_P1 = 0;
endpackage : sixp_pkg

/* File: sixp_port.sv */
// Purpose: six-pin general-purpose port with peripheral output steering
// Assumes: single 10 mhz clock, synchronous active-high reset
// Notes: pins are sampled by three flops; change taken when 2nd/3rd agree
////////////////////////////////////////////////////////////////////////////
module sixp_port #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   input wire logic [5:0] pin_in,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe,
   output logic [5:0] pin_slew_limited,
   output logic [5:0] pin_schmitt_sel,
   output logic [5:0] pin_analog_en,
   input wire logic prog_data_en,
   input wire logic prog_data_out,
   input wire logic wave_a_en,
   input wire logic waveform_a_out,
   input wire logic wave_b_en,
   input wire logic waveform_b_out,
   input wire logic fault_en,
   input wire logic waveform_fault,
   input wire logic conv_en,
   input wire logic converter_output,
   input wire logic cmp_en,
   input wire logic comparator_output,
   input wire logic tx_en,
   input wire logic serial_transmit_clock,
   input wire logic p1_en,
   input wire logic pulse_output_one,
   input wire logic p2_en,
   input wire logic pulse_output_two,
   input wire logic p3_en,
   input wire logic pulse_output_three,
   input wire logic clk_out_en,
   input wire logic clock_output_fn,
   output logic serial_receive_data,
   output logic timer_gate_input
);
   import sixp_pkg::*;

   typedef struct packed {
      logic [5:0] dir;
      logic [5:0] lat;
      logic [5:0] ana;
      logic [5:0] od;
      logic [5:0] slr;
      logic [5:0] thr;
      logic [7:0] steer;
      logic [5:0] s1;
      logic [5:0] s2;
      logic [5:0] s3;
      logic [5:0] lvl;
      logic ack;
      logic err;
      logic [31:0] rdata;
   } sixp_state_t;

   sixp_state_t st_q, st_d;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [5:0] sixp_merge(input logic [5:0] old_v,
                                             input logic [5:0] new_v,
                                             input logic [5:0] msk);
      return (old_v & ~msk) | (new_v & msk);
   endfunction : sixp_merge

   logic [5:0] fn_en;
   logic [5:0] fn_val;
   logic [5:0] dig_in;
   logic [5:0] drv;
   logic hit;
   logic acc;
   logic [5:0] be_mask;
   logic [7:0] be_mask8;

   assign be_mask = avs_byteenable[0] ? 6'h3f : 6'h00;
   assign be_mask8 = avs_byteenable[0] ? 8'hff : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // peripheral output priority per pin
   always_comb begin
      logic wa5, wa2, wb4, wb0, tx4, tx0, p24, p20, p15, p11;
      wa5 = wave_a_en & st_q.steer[SB_WA];
      wa2 = wave_a_en & ~st_q.steer[SB_WA];
      wb4 = wave_b_en & st_q.steer[SB_WB];
      wb0 = wave_b_en & ~st_q.steer[SB_WB];
      tx4 = LARGE_VARIANT & tx_en & st_q.steer[SB_TX];
      tx0 = LARGE_VARIANT & tx_en & ~st_q.steer[SB_TX];
      p24 = p2_en & st_q.steer[SB_P2];
      p20 = p2_en & ~st_q.steer[SB_P2];
      p15 = p1_en & st_q.steer[SB_P1];
      p11 = p1_en & ~st_q.steer[SB_P1];
      fn_en = 6'h00;
      fn_val = 6'h00;
      // pin0
      if (prog_data_en) begin
         fn_en[0] = 1'b1;
         fn_val[0] = prog_data_out;
      end else if (wb0) begin
         fn_en[0] = 1'b1;
         fn_val[0] = waveform_b_out;
      end else if (conv_en) begin
         fn_en[0] = 1'b1;
         fn_val[0] = converter_output;
      end else if (tx0) begin
         fn_en[0] = 1'b1;
         fn_val[0] = serial_transmit_clock;
      end else if (p20) begin
         fn_en[0] = 1'b1;
         fn_val[0] = pulse_output_two;
      end
      // pin1
      if (p11) begin
         fn_en[1] = 1'b1;
         fn_val[1] = pulse_output_one;
      end
      // pin2
      if (wa2) begin
         fn_en[2] = 1'b1;
         fn_val[2] = waveform_a_out;
      end else if (fault_en) begin
         fn_en[2] = 1'b1;
         fn_val[2] = waveform_fault;
      end else if (cmp_en) begin
         fn_en[2] = 1'b1;
         fn_val[2] = comparator_output;
      end else if (p3_en) begin
         fn_en[2] = 1'b1;
         fn_val[2] = pulse_output_three;
      end
      // pin4
      if (clk_out_en) begin
         fn_en[4] = 1'b1;
         fn_val[4] = clock_output_fn;
      end else if (wb4) begin
         fn_en[4] = 1'b1;
         fn_val[4] = waveform_b_out;
      end else if (tx4) begin
         fn_en[4] = 1'b1;
         fn_val[4] = serial_transmit_clock;
      end else if (p24) begin
         fn_en[4] = 1'b1;
         fn_val[4] = pulse_output_two;
      end
      // pin5
      if (wa5) begin
         fn_en[5] = 1'b1;
         fn_val[5] = waveform_a_out;
      end else if (p15) begin
         fn_en[5] = 1'b1;
         fn_val[5] = pulse_output_one;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drive
   // peripheral displaces latch; analog select is not consulted
   assign drv = (fn_en & fn_val) | (~fn_en & st_q.lat);
   always_comb begin
      // direction gates driver; steering never touches dir
      // open drain only enables when driving low
      for (int i = 0; i < NPIN; i++) begin
         pin_out[i] = st_q.od[i] ? 1'b0 : drv[i];
         pin_oe[i] = OUT_MASK[i] & ~st_q.dir[i] & ~(st_q.od[i] & drv[i]);
      end
      pin_oe[INPUT_ONLY_PIN] = 1'b0;
   end
   assign pin_slew_limited = st_q.slr & OUT_MASK;
   assign pin_schmitt_sel = st_q.thr;
   assign pin_analog_en = st_q.ana;

   // analog pins read zero digitally
   assign dig_in = st_q.lvl & ~st_q.ana;
   assign serial_receive_data = st_q.steer[SB_RX] ? dig_in[5] : dig_in[1];
   assign timer_gate_input = st_q.steer[SB_TG] ? dig_in[3] : dig_in[4];

   ////////////////////////////////////////////////////////////////////////
   // bus and state update
   assign hit = (avs_read | avs_write) & ~st_q.ack;
   assign avs_waitrequest = (avs_read | avs_write) & ~st_q.ack;
   // writes land only at the edge where waitrequest is low
   assign acc = (avs_read | avs_write) & st_q.ack;
   assign avs_readdata = st_q.rdata;
   always_comb begin
      logic ok;
      st_d = st_q;
      ok = 1'b1;
      st_d.ack = hit;
      st_d.err = hit & ~(avs_address inside {OFS_DIR, OFS_LVL, OFS_LAT,
         OFS_ANA, OFS_OD, OFS_SLR, OFS_THR, OFS_STEER});
      // three-flop sampler; level moves when 2nd and 3rd agree
      st_d.s1 = pin_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < NPIN; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.lvl[i] = st_q.s3[i];
         end
      end
      if (acc && avs_write) begin
         unique case (avs_address)
            OFS_DIR: st_d.dir = sixp_merge(st_q.dir,
               avs_writedata[5:0] | 6'h08, be_mask);
            // level write: analog-masked read of pins, modified, into latch
            OFS_LVL: st_d.lat = sixp_merge(dig_in,
               avs_writedata[5:0], be_mask) & OUT_MASK;
            OFS_LAT: st_d.lat = sixp_merge(st_q.lat,
               avs_writedata[5:0], be_mask) & OUT_MASK;
            OFS_ANA: st_d.ana = sixp_merge(st_q.ana,
               avs_writedata[5:0], be_mask) & ANA_MASK;
            OFS_OD: st_d.od = sixp_merge(st_q.od,
               avs_writedata[5:0], be_mask) & OUT_MASK;
            OFS_SLR: st_d.slr = sixp_merge(st_q.slr,
               avs_writedata[5:0], be_mask) & OUT_MASK;
            OFS_THR: st_d.thr = sixp_merge(st_q.thr,
               avs_writedata[5:0], be_mask);
            OFS_STEER: st_d.steer = ((st_q.steer & ~be_mask8) |
               (avs_writedata[7:0] & be_mask8)) & STEER_MASK;
            default: ok = 1'b0;
         endcase
      end
      if (hit && avs_read) begin
         st_d.rdata = 32'h0000_0000;
         unique case (avs_address)
            OFS_DIR: st_d.rdata[5:0] = st_q.dir | 6'h08;
            OFS_LVL: st_d.rdata[5:0] = dig_in;
            OFS_LAT: st_d.rdata[5:0] = st_q.lat;
            OFS_ANA: st_d.rdata[5:0] = st_q.ana;
            OFS_OD: st_d.rdata[5:0] = st_q.od;
            OFS_SLR: st_d.rdata[5:0] = st_q.slr;
            OFS_THR: st_d.rdata[5:0] = st_q.thr;
            OFS_STEER: st_d.rdata[7:0] = st_q.steer;
            default: ok = 1'b0;
         endcase
      end
      if (hit) begin
         st_d.rdata = (avs_read && ok) ? st_d.rdata : 32'h0000_0000;
      end
      st_d.rdata[31] = st_d.rdata[31];
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q <= '0;
         st_q.dir <= DIR_RST;
         st_q.lat <= LAT_RST;
         st_q.ana <= ANA_RST;
         st_q.od <= OD_RST;
         st_q.slr <= SLR_RST;
         st_q.thr <= THR_RST;
         st_q.steer <= STEER_RST;
      end else begin
         st_q <= st_d;
      end
   end
   assign avs_response = st_q.err ? 2'b11 : 2'b00;

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_pin3_never_driven;
      @(posedge clk_sys) disable iff (rst) !pin_oe[INPUT_ONLY_PIN];
   endproperty
   a_pin3_never_driven: assert property (p_pin3_never_driven)
      else $error("input-only pin driven");

   property p_dir_hiz;
      @(posedge clk_sys) disable iff (rst) st_q.dir[1] |-> !pin_oe[1];
   endproperty
   a_dir_hiz: assert property (p_dir_hiz)
      else $error("pin driven while direction is input");

   property p_lat_drive;
      @(posedge clk_sys) disable iff (rst)
         (!st_q.dir[1] && !st_q.od[1] && !fn_en[1])
         |-> (pin_oe[1] && pin_out[1] == st_q.lat[1]);
   endproperty
   a_lat_drive: assert property (p_lat_drive)
      else $error("latch not on driven pin");

   property p_analog_zero;
      @(posedge clk_sys) disable iff (rst) st_q.ana[0] |-> !dig_in[0];
   endproperty
   a_analog_zero: assert property (p_analog_zero)
      else $error("analog pin read non-zero");

   sequence s_sync_stable;
      pin_in[2] == 1'b1 [*6];
   endsequence
   property p_sync_lvl;
      @(posedge clk_sys) disable iff (rst)
         s_sync_stable |-> st_q.lvl[2];
   endproperty
   a_sync_lvl: assert property (p_sync_lvl)
      else $error("synchronised level missed stable pin");

   property p_od_no_source;
      @(posedge clk_sys) disable iff (rst)
         (st_q.od[0] && pin_oe[0]) |-> !pin_out[0];
   endproperty
   a_od_no_source: assert property (p_od_no_source)
      else $error("open-drain pin sourcing high");

   property p_prog_priority;
      @(posedge clk_sys) disable iff (rst)
         prog_data_en |-> fn_val[0] == prog_data_out;
   endproperty
   a_prog_priority: assert property (p_prog_priority)
      else $error("pin0 top function lost priority");

   property p_wave_a_route;
      @(posedge clk_sys) disable iff (rst)
         (wave_a_en && st_q.steer[SB_WA]) |->
         (fn_en[5] && fn_val[5] == waveform_a_out && !(fn_en[2] &&
         !fault_en && !cmp_en && !p3_en));
   endproperty
   a_wave_a_route: assert property (p_wave_a_route)
      else $error("wave a not steered to pin5");

   property p_lat_write;
      @(posedge clk_sys) disable iff (rst)
         (acc && avs_write && avs_address == OFS_LAT && avs_byteenable[0])
         |=> st_q.lat == ($past(avs_writedata[5:0]) & OUT_MASK);
   endproperty
   a_lat_write: assert property (p_lat_write)
      else $error("latch write not stored");

   property p_wait_one;
      @(posedge clk_sys) disable iff (rst)
         (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("waitrequest held over one cycle");

   property p_steer_keeps_dir;
      @(posedge clk_sys) disable iff (rst)
         (acc && avs_write && avs_address == OFS_STEER)
         |=> st_q.dir == $past(st_q.dir);
   endproperty
   a_steer_keeps_dir: assert property (p_steer_keeps_dir)
      else $error("steering write moved direction bits");
endmodule : sixp_port

/* File: sixp_pins_model.sv */
// Purpose: external circuitry on the six package pins
// Assumes: bench offers one level per pin for released lines
// Notes: a released line settles to the offered level, never the last driven
module sixp_pins_model (
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe,
   input wire logic [5:0] ext_val,
   output logic [5:0] pin_in
);
   ////////////////////////////////////////////////////////////////////////
   // wire level from both drivers
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_val[i];
      end
   end
endmodule : sixp_pins_model

/* File: sixp_port_test.sv */
// Purpose: register and pin level test of the six-pin port
// Assumes: one wait state per access, pins settle within five cycles
// Notes: peripheral enables and values packed into en and v
module sixp_port_test
   import sixp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] avs_response;
   logic [5:0] pin_in, pin_out, pin_oe, slew, schm, ana;
   logic [5:0] ext_val = 6'h3f;
   logic [10:0] en = 11'h000;
   logic [10:0] v = 11'h000;
   logic rxd, tgate;
   logic [31:0] rd;
   logic [1:0] rsp;
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   logic [7:0] ofs [7] = '{OFS_DIR, OFS_LAT, OFS_ANA, OFS_OD, OFS_SLR,
      OFS_THR, OFS_STEER};
   logic [7:0] rv [7] = '{8'h3f, 8'h00, 8'h17, 8'h00, 8'h37, 8'h00, 8'h00};
   logic [7:0] fv [7] = '{8'h3f, 8'h37, 8'h17, 8'h37, 8'h37, 8'h3f, 8'hef};
   logic [7:0] zv [7] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] cs [5] = '{8'h00, 8'h00, 8'hef, 8'hef, 8'h00};
   logic [7:0] cl [5] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'h37};
   logic [10:0] ce [5] = '{11'h7ff, 11'h37c, 11'h7ff, 11'h3e0, 11'h3e0};
   logic [10:0] cv [5] = '{11'h483, 11'h48f, 11'h1de, 11'h0c0, 11'h300};
   logic [5:0] cx [5] = '{6'h17, 6'h05, 6'h24, 6'h33, 6'h30};
   ////////////////////////////////////////////////////////////////////////
   sixp_port u_sixp_port (.clk_sys(clk_sys), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_slew_limited(slew), .pin_schmitt_sel(schm), .pin_analog_en(ana),
      .prog_data_en(en[0]), .prog_data_out(v[0]),
      .wave_a_en(en[1]), .waveform_a_out(v[1]),
      .wave_b_en(en[2]), .waveform_b_out(v[2]),
      .fault_en(en[3]), .waveform_fault(v[3]),
      .conv_en(en[4]), .converter_output(v[4]),
      .cmp_en(en[5]), .comparator_output(v[5]),
      .tx_en(en[6]), .serial_transmit_clock(v[6]),
      .p1_en(en[7]), .pulse_output_one(v[7]),
      .p2_en(en[8]), .pulse_output_two(v[8]),
      .p3_en(en[9]), .pulse_output_three(v[9]),
      .clk_out_en(en[10]), .clock_output_fn(v[10]),
      .serial_receive_data(rxd), .timer_gate_input(tgate));
   sixp_pins_model u_sixp_pins_model (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_val(ext_val), .pin_in(pin_in));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         give_verdict();
      end
   end
   // one access; answer taken at the edge where waitrequest is low
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [7:0] d);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= 4'hf;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      rsp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask : bus
   task automatic cmp(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : cmp
   task automatic cmp_pin(input string nm, input logic [5:0] e,
         input logic [5:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : cmp_pin
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      cmp("readdata", {24'h0, e}, rd);
   endtask : rdchk
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 7; i++) rdchk(ofs[i], rv[i]);
      rdchk(OFS_LVL, 8'h28);
      cmp("pin_oe", 32'h0, {26'h0, pin_oe});
      bus(1'b1, 8'h20, 8'hff);
      rdchk(8'h20, 8'h00);
      cmp("response", 32'h3, {30'h0, rsp});
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, ofs[i], 8'hff);
         rdchk(ofs[i], fv[i]);
      end
      cmp("slew", 32'h37, {26'h0, slew});
      cmp("schmitt", 32'h3f, {26'h0, schm});
      cmp("analog", 32'h17, {26'h0, ana});
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, ofs[i], 8'h00);
         rdchk(ofs[i], zv[i]);
      end
      cmp("slew", 32'h0, {26'h0, slew});
      cmp("schmitt", 32'h0, {26'h0, schm});
      ext_val <= 6'h00;
      bus(1'b1, OFS_LAT, 8'h15);
      cmp("pin_oe", 32'h37, {26'h0, pin_oe});
      cmp("pin_out", 32'h15, {26'h0, pin_out & 6'h37});
      repeat (4) @(posedge clk_sys);
      rdchk(OFS_LVL, 8'h15);
      rdchk(OFS_LAT, 8'h15);
      bus(1'b1, OFS_LVL, 8'h2a);
      rdchk(OFS_LAT, 8'h22);
      bus(1'b1, OFS_ANA, 8'hff);
      repeat (4) @(posedge clk_sys);
      rdchk(OFS_LVL, 8'h20);
      cmp("pin_oe", 32'h37, {26'h0, pin_oe});
      cmp("pin_out", 32'h22, {26'h0, pin_out & 6'h37});
      bus(1'b1, OFS_OD, 8'hff);
      cmp("pin_oe", 32'h15, {26'h0, pin_oe});
      cmp("pin_out", 32'h0, {26'h0, pin_out & pin_oe});
      bus(1'b1, OFS_OD, 8'h00);
      bus(1'b1, OFS_ANA, 8'h00);
      for (int k = 0; k < 5; k++) begin
         bus(1'b1, OFS_STEER, cs[k]);
         bus(1'b1, OFS_LAT, cl[k]);
         en <= ce[k];
         v <= cv[k];
         repeat (5) @(posedge clk_sys);
         cmp_pin("pin_out", cx[k], pin_out & 6'h37);
         cmp_pin("lo", cx[k] & 6'h07, pin_out & 6'h07);
         cmp_pin("hi", cx[k] & 6'h30, pin_out & 6'h30);
         cmp("pin_oe", 32'h37, {26'h0, pin_oe});
         rdchk(OFS_LVL, {2'b00, cx[k]});
      end
      en <= 11'h000;
      bus(1'b1, OFS_DIR, 8'hff);
      ext_val <= 6'h28;
      bus(1'b1, OFS_STEER, 8'h88);
      repeat (4) @(posedge clk_sys);
      cmp("rx", 32'h1, {31'h0, rxd});
      cmp("gate", 32'h1, {31'h0, tgate});
      rdchk(OFS_DIR, 8'h3f);
      bus(1'b1, OFS_STEER, 8'h00);
      repeat (4) @(posedge clk_sys);
      cmp("rx", 32'h0, {31'h0, rxd});
      cmp("gate", 32'h0, {31'h0, tgate});
      give_verdict();
   end
endmodule : sixp_port_test
